//--- hdl/ctm_timer.sv
// Compact 10-bit timer: compare-match, timer/counter and edge-aligned PWM modes.
//
// Summary of operation
// - Mode field: 00 compare, 11 timer, 10 PWM.
// - Clear-select low: clear on P match or overflow.
// - Clear-select low: raise both A and P flags.
// - Clear-select high: clear on A, only A flag.
// - A zero, clear-select high: overflow, no A flag.
// - Compare pin changes only on A match or enable rise.
// - Function field: low, high, toggle, zero holds.
// - Enable rising edge loads pin initial level.
// - Timer mode counts like compare, pin undriven.
// - PWM ignores the clear-select bit.
// - PWM: one comparator period, other duty.
// - PWM raises A and P flags on matches.
// - PWM: control bit sets level, field forces.
// - Polarity bit inverts the driven waveform.
// - PWM keeps running while pin is forced.
// - Swap clear: period 128 times P code, code zero 1024.
// - Duty at or above period gives full duty.
// - Swap set: A period, duty 128 times code, code zero 1024.
// - Swap bit zero: P period, A duty.
// - Control bit zero active low, one high.
`timescale 1ns/1ps

module ctm_timer (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               count_tick,
  input  wire ctm_pkg::ctm_cfg_s  cfg,
  input  wire logic               a_flag_clr,
  input  wire logic               p_flag_clr,
  output ctm_pkg::ctm_stat_s      stat
);

  ctm_pkg::ctm_state_s st_reg;
  ctm_pkg::ctm_state_s st_next;
  ctm_pkg::ctm_mode_e  mode;
  logic [1:0]          out_func;
  logic                en_rise;
  logic                run;
  logic [10:0]         cnt_x;
  logic [10:0]         p_period;
  logic [10:0]         a_period;
  logic [10:0]         period;
  logic [10:0]         duty;
  logic                p_hit;
  logic                a_hit;
  logic                a_ovf_end;
  logic                a_ev;
  logic                p_ev;
  logic                clr_cnt;
  logic                pwm_active;
  logic                pwm_level;

  // Field decode and comparator geometry shared by every mode.
  assign mode     = ctm_pkg::ctm_mode_e'({cfg.mode_sel_hi, cfg.mode_sel_lo});
  assign out_func = {cfg.out_func_hi, cfg.out_func_lo};
  assign en_rise  = cfg.timer_enable & ~st_reg.en_d;
  assign run      = cfg.timer_enable & count_tick & ~en_rise;
  assign cnt_x    = {1'b0, st_reg.cnt};

  // P code zero means a full 1024-count period, so the P end lands on overflow.
  assign p_period = (cfg.compare_p_value == 3'h0) ? ctm_pkg::CTM_FULL_PER
                  : {1'b0, cfg.compare_p_value, ctm_pkg::CTM_P_LOW};
  assign a_period = (cfg.compare_a_value == 10'h000) ? ctm_pkg::CTM_FULL_PER
                  : {1'b0, cfg.compare_a_value};

  // A match is taken on the tick that carries the counter up to the compare value.
  assign p_hit     = (cnt_x == p_period - 11'h001);
  assign a_ovf_end = (cnt_x == a_period - 11'h001);
  assign a_hit     = (cfg.compare_a_value != 10'h000) && a_ovf_end;

  // PWM period and duty follow the swap bit; clear-select plays no part.
  assign period = cfg.period_duty_swap ? a_period : p_period;
  assign duty   = cfg.period_duty_swap ? p_period
                : {1'b0, cfg.compare_a_value};

  // Counter below duty is the active phase; duty at or past period never leaves it.
  assign pwm_active = (cnt_x < duty) || (duty >= period);
  assign pwm_level  = pwm_active ? cfg.out_control : ~cfg.out_control;

  // Match events, counter clear choice and flag qualification per mode.
  always_comb begin
    a_ev    = 1'b0;
    p_ev    = 1'b0;
    clr_cnt = 1'b0;
    unique case (mode)
      ctm_pkg::CTM_MODE_CMP, ctm_pkg::CTM_MODE_TC: begin
        if (cfg.clear_select) begin
          a_ev    = run & a_hit;
          clr_cnt = a_ovf_end;
        end else begin
          a_ev    = run & a_hit;
          p_ev    = run & p_hit;
          clr_cnt = p_hit;
        end
      end
      ctm_pkg::CTM_MODE_PWM: begin
        a_ev    = run & a_hit;
        p_ev    = run & p_hit;
        clr_cnt = (cnt_x == period - 11'h001);
      end
      ctm_pkg::CTM_MODE_CAP: begin
        clr_cnt = (st_reg.cnt == ctm_pkg::CTM_CNT_MAX);
      end
    endcase
  end

  // Next state: counter, flags, compare level and the registered pin.
  always_comb begin
    st_next      = st_reg;
    st_next.en_d = cfg.timer_enable;
    if (en_rise) begin
      st_next.cnt      = ctm_pkg::CTM_CNT_RST;
      st_next.cm_level = cfg.out_control;
    end else if (run) begin
      if (clr_cnt) begin
        st_next.cnt = ctm_pkg::CTM_CNT_RST;
      end else begin
        st_next.cnt = st_reg.cnt + 10'h001;
      end
    end
    // Besides the enable-rise load, only an A match moves the compare level; P matches never touch it.
    if (a_ev && mode == ctm_pkg::CTM_MODE_CMP) begin
      unique case (out_func)
        ctm_pkg::CTM_OF_NONE:   st_next.cm_level = st_reg.cm_level;
        ctm_pkg::CTM_OF_LOW:    st_next.cm_level = 1'b0;
        ctm_pkg::CTM_OF_HIGH:   st_next.cm_level = 1'b1;
        ctm_pkg::CTM_OF_TOGGLE: st_next.cm_level = ~st_reg.cm_level;
      endcase
    end
    // A new event beats a clear arriving in the same cycle.
    st_next.a_flag = a_ev | (st_reg.a_flag & ~a_flag_clr);
    st_next.p_flag = p_ev | (st_reg.p_flag & ~p_flag_clr);
    // Pin level; the PWM counter runs regardless of a forced output.
    unique case (mode)
      ctm_pkg::CTM_MODE_CMP: begin
        st_next.pin_oe = 1'b1;
        st_next.pin    = st_next.cm_level ^ cfg.out_polarity;
      end
      ctm_pkg::CTM_MODE_PWM: begin
        st_next.pin_oe = 1'b1;
        case (out_func)
          ctm_pkg::CTM_PF_INACT: st_next.pin = ~cfg.out_control ^ cfg.out_polarity;
          ctm_pkg::CTM_PF_ACT:   st_next.pin = cfg.out_control ^ cfg.out_polarity;
          ctm_pkg::CTM_PF_WAVE:  st_next.pin = pwm_level ^ cfg.out_polarity;
          default:               st_next.pin = st_reg.pin;
        endcase
      end
      ctm_pkg::CTM_MODE_TC, ctm_pkg::CTM_MODE_CAP: begin
        st_next.pin_oe = 1'b0;
        st_next.pin    = st_reg.pin;
      end
    endcase
  end

  // Single state register; all outputs come straight from it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ctm_pkg::CTM_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // One assignment drives the whole status struct, so it has a single driver.
  assign stat = '{count_value: st_reg.cnt, a_match_flag: st_reg.a_flag,
                  p_match_flag: st_reg.p_flag, out_pin: st_reg.pin, out_pin_oe: st_reg.pin_oe};

  // Checks on the counter, flags and pin.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic nonpwm;
  assign nonpwm = (mode == ctm_pkg::CTM_MODE_CMP) || (mode == ctm_pkg::CTM_MODE_TC);

  p_clear_a: assert property (
    nonpwm && !cfg.clear_select && run && p_hit |=> stat.count_value == 10'h000 && stat.p_match_flag)
    else $error("P match did not clear counter and raise P flag");

  a_flag_set_a: assert property (
    nonpwm && run && a_hit && !en_rise |=> stat.a_match_flag)
    else $error("A match did not raise A flag");

  p_flag_block_a: assert property (
    nonpwm && cfg.clear_select && !p_flag_clr |=> !$rose(stat.p_match_flag))
    else $error("P flag raised with clear-select high");

  a_zero_ovf_a: assert property (
    nonpwm && cfg.clear_select && cfg.compare_a_value == 10'h000 && run
      && stat.count_value == 10'h3ff && !stat.a_match_flag && !a_flag_clr
    |=> stat.count_value == 10'h000 && !stat.a_match_flag)
    else $error("Overflow with A zero misbehaved");

  pin_hold_a: assert property (
    mode == ctm_pkg::CTM_MODE_CMP && !a_ev && !en_rise && $stable(cfg) && $stable(mode)
    |=> $stable(stat.out_pin))
    else $error("Compare pin moved without A match");

  pin_init_a: assert property (
    mode == ctm_pkg::CTM_MODE_CMP && en_rise
    |=> stat.out_pin == $past(cfg.out_control ^ cfg.out_polarity) && stat.count_value == 10'h000)
    else $error("Enable rise did not load initial pin level");

  tc_no_drive_a: assert property (
    mode == ctm_pkg::CTM_MODE_TC |=> !stat.out_pin_oe)
    else $error("Pin driven in timer/counter mode");

  pwm_wrap_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && run && cnt_x == period - 11'h001
    |=> stat.count_value == 10'h000)
    else $error("PWM counter did not clear at period end");

  pwm_force_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && out_func == ctm_pkg::CTM_PF_INACT
    |=> stat.out_pin == $past(~cfg.out_control ^ cfg.out_polarity))
    else $error("Forced inactive level wrong");

  pwm_full_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && out_func == ctm_pkg::CTM_PF_WAVE && duty >= period
    |=> stat.out_pin == $past(cfg.out_control ^ cfg.out_polarity))
    else $error("Full duty not held");

  // Mode decode: compare and PWM drive the pin, the other codes leave it free.
  mode_drive_a: assert property (
    (mode == ctm_pkg::CTM_MODE_CMP || mode == ctm_pkg::CTM_MODE_PWM) |=> stat.out_pin_oe)
    else $error("Pin not driven in an output mode");

  cap_free_a: assert property (
    mode == ctm_pkg::CTM_MODE_CAP |=> !stat.out_pin_oe && !$rose(stat.a_match_flag))
    else $error("Unsupported mode drove the pin or raised the A flag");

  // Counter clearing in the compare and timer/counter modes.
  p_zero_ovf_a: assert property (
    nonpwm && !cfg.clear_select && cfg.compare_p_value == 3'h0 && run
      && stat.count_value == 10'h3ff
    |=> stat.count_value == 10'h000)
    else $error("Counter did not overflow with P code zero");

  a_clear_a: assert property (
    nonpwm && cfg.clear_select && run && a_hit
    |=> stat.count_value == 10'h000 && stat.a_match_flag)
    else $error("A match did not clear the counter with clear-select high");

  p_code_a: assert property (
    nonpwm && !cfg.clear_select && p_ev && cfg.compare_p_value != 3'h0
    |-> stat.count_value[6:0] == 7'h7f && stat.count_value[9:7] == cfg.compare_p_value - 3'h1)
    else $error("P match off the top-bit boundary");

  // Pin actions on an A match in compare mode; polarity must hold still to judge toggle and no-change.
  cm_low_a: assert property (
    mode == ctm_pkg::CTM_MODE_CMP && a_ev && out_func == ctm_pkg::CTM_OF_LOW
    |=> stat.out_pin == $past(cfg.out_polarity))
    else $error("Drive-low action wrong");

  cm_high_a: assert property (
    mode == ctm_pkg::CTM_MODE_CMP && a_ev && out_func == ctm_pkg::CTM_OF_HIGH
    |=> stat.out_pin == !$past(cfg.out_polarity))
    else $error("Drive-high action wrong");

  cm_toggle_a: assert property (
    mode == ctm_pkg::CTM_MODE_CMP && $stable(mode) && $stable(cfg.out_polarity) && a_ev
      && out_func == ctm_pkg::CTM_OF_TOGGLE
    |=> stat.out_pin != $past(stat.out_pin))
    else $error("Toggle action did not toggle");

  cm_none_a: assert property (
    mode == ctm_pkg::CTM_MODE_CMP && $stable(mode) && $stable(cfg.out_polarity) && a_ev
      && out_func == ctm_pkg::CTM_OF_NONE
    |=> $stable(stat.out_pin))
    else $error("No-change action moved the pin");

  // PWM period, duty, flags and levels.
  pwm_p_period_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && !cfg.period_duty_swap && run && p_hit
    |=> stat.count_value == 10'h000)
    else $error("P end did not clear the PWM counter");

  pwm_a_period_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && cfg.period_duty_swap && run && a_ovf_end
    |=> stat.count_value == 10'h000)
    else $error("A end did not clear the swapped PWM counter");

  pwm_aflag_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && run && a_hit |=> stat.a_match_flag)
    else $error("PWM A match did not raise A flag");

  pwm_pflag_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && run && p_hit |=> stat.p_match_flag)
    else $error("PWM P match did not raise P flag");

  pwm_act_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && out_func == ctm_pkg::CTM_PF_WAVE && duty < period
      && cnt_x < duty
    |=> stat.out_pin == $past(cfg.out_control ^ cfg.out_polarity))
    else $error("Active phase level wrong");

  pwm_inact_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && out_func == ctm_pkg::CTM_PF_WAVE && duty < period
      && cnt_x >= duty
    |=> stat.out_pin == $past(~cfg.out_control ^ cfg.out_polarity))
    else $error("Inactive phase level wrong");

  pwm_force_act_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && out_func == ctm_pkg::CTM_PF_ACT
    |=> stat.out_pin == $past(cfg.out_control ^ cfg.out_polarity))
    else $error("Forced active level wrong");

  pwm_runs_a: assert property (
    mode == ctm_pkg::CTM_MODE_PWM && run && out_func != ctm_pkg::CTM_PF_WAVE
      && cnt_x != period - 11'h001
    |=> stat.count_value == $past(stat.count_value) + 10'h001)
    else $error("PWM counter stalled while the pin was forced");

endmodule

//--- hdl/ctm_pkg.sv
// Constants, modes and carrier structs for the compact timer mode logic.
package ctm_pkg;

  // Counter geometry: 10-bit up-counter, P code compared with the top three bits.
  localparam int          CTM_CNT_W    = 10;
  localparam int          CTM_P_W      = 3;
  localparam int          CTM_P_SHIFT  = 7;
  localparam logic [9:0]  CTM_CNT_MAX  = 10'h3ff;
  localparam logic [9:0]  CTM_CNT_RST  = 10'h000;
  localparam logic [10:0] CTM_FULL_PER = 11'h400;
  localparam logic [6:0]  CTM_P_LOW    = 7'h00;

  // Operating modes selected by the two mode-select bits.
  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'b00,
    CTM_MODE_CAP = 2'b01,
    CTM_MODE_PWM = 2'b10,
    CTM_MODE_TC  = 2'b11
  } ctm_mode_e;

  // Output-function codes in compare-match mode.
  localparam logic [1:0] CTM_OF_NONE   = 2'h0;
  localparam logic [1:0] CTM_OF_LOW    = 2'h1;
  localparam logic [1:0] CTM_OF_HIGH   = 2'h2;
  localparam logic [1:0] CTM_OF_TOGGLE = 2'h3;

  // Output-function codes in PWM mode.
  localparam logic [1:0] CTM_PF_INACT = 2'h0;
  localparam logic [1:0] CTM_PF_ACT   = 2'h1;
  localparam logic [1:0] CTM_PF_WAVE  = 2'h2;

  // Software control bits of the timer.
  typedef struct packed {
    logic       timer_enable;
    logic       mode_sel_hi;
    logic       mode_sel_lo;
    logic       out_func_hi;
    logic       out_func_lo;
    logic       out_control;
    logic       out_polarity;
    logic       period_duty_swap;
    logic       clear_select;
    logic [9:0] compare_a_value;
    logic [2:0] compare_p_value;
  } ctm_cfg_s;

  // Status seen by software and the pin.
  typedef struct packed {
    logic [9:0] count_value;
    logic       a_match_flag;
    logic       p_match_flag;
    logic       out_pin;
    logic       out_pin_oe;
  } ctm_stat_s;

  // Whole internal state of the timer.
  typedef struct packed {
    logic [9:0] cnt;
    logic       en_d;
    logic       cm_level;
    logic       a_flag;
    logic       p_flag;
    logic       pin;
    logic       pin_oe;
  } ctm_state_s;

  localparam ctm_state_s CTM_STATE_RST = '{cnt: 10'h000, en_d: 1'b0, cm_level: 1'b0,
                                           a_flag: 1'b0, p_flag: 1'b0, pin: 1'b0,
                                           pin_oe: 1'b0};

endpackage

//--- tb/ctm_timer_tb_top.sv
// Self-checking bench for the compact timer mode logic.
`timescale 1ns/1ps

module ctm_timer_tb_top;
  localparam logic [1:0] cm_md = 2'h0;
  localparam logic [1:0] cp_md = 2'h1;
  localparam logic [1:0] pw_md = 2'h2;
  localparam logic [1:0] tc_md = 2'h3;

  logic               mclk;
  logic               rst_n;
  logic               count_tick;
  ctm_pkg::ctm_cfg_s  cfg;
  logic               a_flag_clr;
  logic               p_flag_clr;
  ctm_pkg::ctm_stat_s stat;
  int                 error_cnt;
  int                 total_checks;
  int                 test_no;

  ctm_timer ctm_timer_inst (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .count_tick (count_tick),
    .cfg        (cfg),
    .a_flag_clr (a_flag_clr),
    .p_flag_clr (p_flag_clr),
    .stat       (stat)
  );

  // Free-running 20 MHz clock.
  always #25 mclk = ~mclk;

  // Builds a configuration with the enable bit low, so a run always starts from a rise.
  function automatic ctm_pkg::ctm_cfg_s mk(input logic [1:0] m, input logic [1:0] f,
                                           input int oc, input int pol, input int sw,
                                           input int cc, input int a, input int p);
    mk = '{1'b0, m[1], m[0], f[1], f[0], oc[0], pol[0], sw[0], cc[0], a[9:0], p[2:0]};
  endfunction

  // Compares the counter value.
  task automatic chk_cnt(input logic [9:0] e, input logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Compares flags, pin and enable under a mask; an unknown in a checked bit never matches.
  task automatic chk_bits(input logic [3:0] e, input logic [3:0] g, input logic [3:0] m);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask

  // Clears flags while off, enables, gives n back-to-back ticks, then checks.
  // Expected bits are {a flag, p flag, pin, pin enable}.
  task automatic run(input ctm_pkg::ctm_cfg_s c, input int n, input int ecnt,
                     input logic [3:0] e, input logic [3:0] m);
    @(posedge mclk);
    cfg        <= c;
    a_flag_clr <= 1'b1;
    p_flag_clr <= 1'b1;
    @(posedge mclk);
    cfg.timer_enable <= 1'b1;
    a_flag_clr       <= 1'b0;
    p_flag_clr       <= 1'b0;
    @(posedge mclk);
    if (n > 0) begin
      count_tick <= 1'b1;
      repeat (n) @(posedge mclk);
      count_tick <= 1'b0;
    end
    #1;
    chk_cnt(ecnt[9:0], stat.count_value);
    chk_bits(e, {stat.a_match_flag, stat.p_match_flag, stat.out_pin, stat.out_pin_oe}, m);
    test_no++;
    $display("test %0d done", test_no);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole sequence needs under a seventh of this span.
  initial begin
    #2000000;
    error_cnt++;
    conclude();
  end

  // Main sequence: reset for four cycles, then the mode scenarios.
  initial begin
    mclk         = 1'b0;
    rst_n        = 1'b0;
    count_tick   = 1'b0;
    cfg          = '0;
    a_flag_clr   = 1'b0;
    p_flag_clr   = 1'b0;
    error_cnt    = 0;
    total_checks = 0;
    test_no      = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    run(mk(cm_md, 2'h3, 1, 0, 0, 0, 5, 1), 0, 0, 4'b0011, 4'hf);         // Start.
    run(mk(cm_md, 2'h3, 0, 0, 0, 0, 5, 1), 4, 4, 4'b0001, 4'hf);         // Pre-match.
    run(mk(cm_md, 2'h3, 0, 0, 0, 0, 5, 1), 5, 5, 4'b1011, 4'hf);         // A.
    run(mk(cm_md, 2'h3, 0, 0, 0, 0, 5, 1), 127, 127, 4'b1011, 4'hf);     // Edge.
    run(mk(cm_md, 2'h3, 0, 0, 0, 0, 5, 1), 128, 0, 4'b1111, 4'hf);       // P.
    for (int f = 0; f < 4; f++) begin
      run(mk(cm_md, f[1:0], 1, 0, 0, 0, 5, 1), 5, 5, {2'b10, ~f[0], 1'b1},
          4'hf);                                                         // Codes.
    end
    run(mk(tc_md, 2'h3, 0, 0, 0, 0, 5, 1), 128, 0, 4'b1100, 4'b1101);    // Free pin.
    run(mk(cp_md, 2'h3, 0, 0, 0, 0, 5, 1), 130, 130, 4'b0000, 4'b1101);  // Spare code.
    run(mk(cm_md, 2'h3, 0, 0, 0, 1, 300, 1), 300, 0, 4'b1011, 4'hf);     // A clear.
    run(mk(cm_md, 2'h3, 0, 0, 0, 1, 0, 1), 1023, 10'h3ff, 4'b0001, 4'hf); // Top.
    run(mk(cm_md, 2'h3, 0, 0, 0, 1, 0, 1), 1024, 0, 4'b0001, 4'hf);      // Wrap.
    run(mk(cm_md, 2'h3, 0, 0, 0, 0, 700, 0), 1024, 0, 4'b1111, 4'hf);    // Overflow.
    run(mk(pw_md, 2'h2, 1, 0, 0, 0, 32, 1), 10, 10, 4'b0011, 4'hf);      // On.
    run(mk(pw_md, 2'h2, 1, 0, 0, 0, 32, 1), 60, 60, 4'b1001, 4'hf);      // Off.
    run(mk(pw_md, 2'h2, 1, 0, 0, 0, 32, 1), 138, 10, 4'b1111, 4'hf);     // Period.
    run(mk(pw_md, 2'h2, 0, 0, 0, 0, 32, 1), 10, 10, 4'b0001, 4'hf);      // Low active.
    run(mk(pw_md, 2'h2, 1, 1, 0, 0, 32, 1), 10, 10, 4'b0001, 4'hf);      // Inverted.
    run(mk(pw_md, 2'h2, 1, 0, 0, 0, 200, 1), 120, 120, 4'b0011, 4'hf);   // Full duty.
    run(mk(pw_md, 2'h0, 1, 0, 0, 0, 32, 1), 10, 10, 4'b0001, 4'hf);      // Forced.
    run(mk(pw_md, 2'h1, 1, 0, 0, 0, 32, 1), 60, 60, 4'b1011, 4'hf);      // Forced.
    run(mk(pw_md, 2'h0, 1, 0, 0, 0, 32, 1), 138, 10, 4'b1101, 4'hf);     // Runs on.
    run(mk(pw_md, 2'h2, 1, 0, 1, 0, 300, 1), 10, 10, 4'b0011, 4'hf);     // Swap on.
    run(mk(pw_md, 2'h2, 1, 0, 1, 0, 300, 1), 200, 200, 4'b0101, 4'hf);   // Swap off.
    run(mk(pw_md, 2'h2, 1, 0, 1, 0, 300, 1), 310, 10, 4'b1111, 4'hf);    // Swap period.
    run(mk(pw_md, 2'h2, 1, 0, 0, 1, 32, 1), 138, 10, 4'b1111, 4'hf);     // Clear bit moot.
    conclude();
  end
endmodule
